// [map_bus_mux.sv]
`timescale 1ns/1ns
`default_nettype none
module map_bus_mux
   import map_pkg::*;
(
   input  wire logic         clock_i,
   input  wire logic         nrst_i,
   input  wire logic         dbg_valid_i,
   input  wire map_mem_req_t dbg_req_i,
   output logic             dbg_done_o,
   input  wire logic         slv_valid_i,
   input  wire map_mem_req_t slv_req_i,
   input  wire logic         slv_enable_i,
   output logic             slv_done_o,
   output logic             slv_refused_o,
   output logic             mem_valid_o,
   output map_mem_req_t     mem_req_o,
   input  wire logic         mem_done_i
);
   logic         busy_q;
   logic         own_slv_q;
   logic         slv_ok;
   logic         own_slv;
   map_mem_req_t slv_fixed;

   assign slv_ok      = slv_valid_i & slv_enable_i;
   // Owner is held for the whole access so data cannot switch mid-beat
   assign own_slv     = busy_q ? own_slv_q : (~dbg_valid_i & slv_ok);
   assign mem_valid_o = busy_q | dbg_valid_i | slv_ok;
   // (R16) slave address bit 31 low
   always_comb begin
      slv_fixed          = slv_req_i;
      slv_fixed.addr[31] = 1'b0;
   end
   assign mem_req_o     = own_slv ? slv_fixed : dbg_req_i;
   assign dbg_done_o    = mem_done_i & mem_valid_o & ~own_slv;
   // Disabled slave port is answered at once with an error
   assign slv_refused_o = slv_valid_i & ~slv_enable_i;
   assign slv_done_o    = (mem_done_i & mem_valid_o & own_slv) | slv_refused_o;

   always_ff @(posedge clock_i) begin
      if (!nrst_i) begin
         busy_q    <= 1'b0;
         own_slv_q <= 1'b0;
      end else begin
         busy_q    <= mem_valid_o & ~mem_done_i;
         own_slv_q <= own_slv;
      end
   end

   a_slave_addr_low: assert property (@(posedge clock_i) disable iff (!nrst_i)
      mem_valid_o && own_slv |-> !mem_req_o.addr[31]) // R16
      else $error("slave access left address bit 31 set");
   c_slave_access: cover property (@(posedge clock_i) disable iff (!nrst_i)
      mem_valid_o && own_slv && mem_done_i);
endmodule // map_bus_mux
`default_nettype wire

// [map_mem_model.sv]
`timescale 1ns/1ns
`default_nettype none
module map_mem_model
   import map_pkg::*;
(
   input  wire logic         clock_i,
   input  wire logic         valid_i,
   input  wire map_mem_req_t req_i,
   input  wire logic [1:0]   wait_i,
   input  wire logic [31:0]  err_addr_i,
   output logic              done_o,
   output map_mem_rsp_t      rsp_o
);
   logic [7:0]  mem [0:63];
   logic [31:0] la [$];
   logic [3:0]  lb [$];
   logic [1:0]  cnt;
   logic [5:0]  wa;
   logic        hit;

   assign wa  = {req_i.addr[5:2], 2'h0};
   assign hit = (req_i.addr == err_addr_i);

   initial begin
      for (int i = 0; i < 64; i++) begin
         mem[i] = 8'(i);
      end
      done_o = 1'b0;
      rsp_o  = '0;
      cnt    = 2'h0;
   end

   // Idle response lines toggle so stale data never looks valid
   always @(posedge clock_i) begin
      done_o <= 1'b0;
      rsp_o  <= ~rsp_o;
      if (valid_i && !done_o) begin
         if (cnt != wait_i) begin
            cnt <= cnt + 2'h1;
         end else begin
            cnt         <= 2'h0;
            done_o      <= 1'b1;
            rsp_o.err   <= hit;
            rsp_o.rdata <= {mem[wa+3], mem[wa+2], mem[wa+1], mem[wa]};
            la.push_back(req_i.addr);
            lb.push_back(req_i.be);
            for (int b = 0; b < 4; b++) begin
               if (req_i.write && !hit && req_i.be[b]) begin
                  mem[wa+b] <= req_i.wdata[8*b +: 8];
               end
            end
         end
      end
   end
endmodule // map_mem_model
`default_nettype wire

// [map_packer.sv]
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// (R1) Packed mode only when the increment mode field holds 0b10.
// (R2) Packed word size: one 32-bit memory access per data access.
// (R3) Packed halfword size: two 16-bit memory accesses per data access.
// (R4) Packed byte size: four 8-bit memory accesses per data access.
// (R5) Debugger must not use packed mode with sizes above a word.
// (R6) Each successful packed access adds the size in bytes to the address.
// (R7) Accesses of one packed transfer go in ascending address order.
// (R8) Halfwords use bits 15:0 or 31:16 from address bit 1.
// (R9) Bytes use the lane picked by address bits 1:0.
// (R10) Reads merge into lanes and answer only with the whole word.
// (R11) An error response stops the sequence and reports an error.
// (R12) Compare flag may set only after a whole word is packed.
// (R13) Every counted repeated transaction is split the same way.
// (R14) Enable bit reads zero when neither slave port nor gate exists.
// (R15) When the port is disabled the enable bit acts as one.
// (R16) Slave port shares the bus with bit 31 of its address forced low.
// (R17) Debugger may mimic slave accesses by clearing address bit 31.
// (R18) Enable bit gates the slave port and resets to one.
// (R19) Gate output follows the enable bit and resets high.
// (R20) Debugger should avoid clearing the enable bit.
// (R21) A memory error reported upward sets the sticky error flag.
// (R22) Outside packed mode one access per data access, plain laning.
// (R23) Not ready while a sequence runs, so new requests wait.
module map_packer
   import map_pkg::*;
#(
   parameter bit HAS_PACKING    = 1'b1,
   parameter bit HAS_SLAVE_PORT = 1'b1,
   parameter bit HAS_SW_GATE    = 1'b1
) (
   input  wire logic         clock_i,
   input  wire logic         nrst_i,
   input  wire logic         ap_valid_i,
   input  wire map_ap_req_t  ap_req_i,
   output logic             ap_ready_o,
   output logic             ap_resp_valid_o,
   output logic [31:0]      ap_rdata_o,
   output logic             ap_err_o,
   input  wire logic         sticky_clr_i,
   output logic             sticky_err_o,
   output logic             sticky_cmp_o,
   input  wire logic         ap_disabled_i,
   output logic             software_debug_gate_o,
   input  wire logic         slv_valid_i,
   input  wire map_mem_req_t slv_req_i,
   output logic             slv_done_o,
   output map_mem_rsp_t     slv_rsp_o,
   output logic             mem_valid_o,
   output map_mem_req_t     mem_req_o,
   input  wire logic         mem_done_i,
   input  wire map_mem_rsp_t mem_rsp_i
);
   map_state_t   state_q, state_d;
   logic [2:0]   size_q, size_d;
   logic [1:0]   inc_q, inc_d;
   logic         swen_q, swen_d;
   logic [31:0]  tar_q, tar_d;
   logic [31:0]  drw_q, drw_d;
   logic [31:0]  rdata_q, rdata_d;
   logic [31:0]  cmp_q, cmp_d;
   logic [2:0]   beats_q, beats_d;
   logic         write_q, write_d;
   logic         push_q, push_d;
   logic         err_q, err_d;
   logic         serr_q, scmp_q;

   function automatic logic [3:0] map_lanes(input logic [2:0] sz,
                                            input logic [1:0] a);
      logic [3:0] be;
      be = 4'hF;
      if (sz == MAP_SIZE_BYTE)
         be = 4'h1 << a;
      else if (sz == MAP_SIZE_HALF)
         be = a[1] ? 4'hC : 4'h3;
      return be;
   endfunction

   logic         packed_on;
   logic         take;
   logic         take_drw;
   logic [31:0]  step;
   logic [31:0]  align_mask;
   logic [2:0]   beats_init;
   logic [3:0]   lane_be;
   logic [31:0]  merged;
   logic [31:0]  csw_rd;
   logic         swen_eff;
   logic         swen_rd;
   logic         dbg_valid;
   logic         dbg_done;
   logic         slv_refused;
   logic         beat_ok;
   logic         beat_err;
   logic         last_beat;
   logic         cmp_miss;
   logic [2:0]   wr_size;
   map_mem_req_t dbg_req;

   // (R1) packed mode from increment field
   assign packed_on  = HAS_PACKING && (inc_q == MAP_INC_PACKED);
   // (R23) ready only while idle
   assign ap_ready_o = (state_q == MAP_ST_IDLE);
   assign take       = ap_valid_i & ap_ready_o;
   assign take_drw   = take & (ap_req_i.sel == MAP_SEL_DRW);
   assign step       = 32'h1 << size_q;
   assign align_mask = ~(step - 32'h1);
   // (R2) (R3) (R4) (R13) beats per data access
   // (R22) single beat outside packed mode
   assign beats_init = packed_on ? (3'h4 >> size_q) : 3'h1;
   // (R8) (R9) lane choice from the address
   assign lane_be    = map_lanes(size_q, tar_q[1:0]);

   // (R10) read data merged into its own lanes
   for (genvar i = 0; i < 4; i++) begin : g_lane
      assign merged[i*8 +: 8] = lane_be[i] ? mem_rsp_i.rdata[i*8 +: 8]
                                           : drw_q[i*8 +: 8];
   end

   // (R15) disabled port forces the enable on
   assign swen_eff = swen_q | ap_disabled_i;
   // (R14) read as zero without either feature
   assign swen_rd  = (HAS_SLAVE_PORT | HAS_SW_GATE) & swen_q;
   // (R19) gate follows the effective enable
   assign software_debug_gate_o = HAS_SW_GATE & swen_eff;
   assign csw_rd = {swen_rd, 23'h0, ~ap_ready_o, 1'b0, inc_q, 1'b0,
                    size_q};

   // Unaligned address bits are ignored on the bus side
   always_comb begin
      dbg_req       = '0;
      dbg_req.write = write_q;
      dbg_req.addr  = tar_q & align_mask;
      dbg_req.size  = size_q;
      dbg_req.be    = lane_be;
      dbg_req.wdata = drw_q;
   end
   assign dbg_valid = (state_q == MAP_ST_XFER);

   // (R18) enable bit gates the slave port
   map_bus_mux u_mux (
      .clock_i       (clock_i),
      .nrst_i        (nrst_i),
      .dbg_valid_i   (dbg_valid),
      .dbg_req_i     (dbg_req),
      .dbg_done_o    (dbg_done),
      .slv_valid_i   (slv_valid_i),
      .slv_req_i     (slv_req_i),
      .slv_enable_i  (HAS_SLAVE_PORT & swen_eff),
      .slv_done_o    (slv_done_o),
      .slv_refused_o (slv_refused),
      .mem_valid_o   (mem_valid_o),
      .mem_req_o     (mem_req_o),
      .mem_done_i    (mem_done_i)
   );
   assign slv_rsp_o.err   = slv_refused | mem_rsp_i.err;
   assign slv_rsp_o.rdata = slv_refused ? 32'h0 : mem_rsp_i.rdata;

   assign beat_ok   = dbg_done & ~mem_rsp_i.err;
   assign beat_err  = dbg_done & mem_rsp_i.err;
   assign last_beat = beat_ok & (beats_q == 3'h1);
   // (R12) compare only on the completed word
   assign cmp_miss  = last_beat & push_q & ~write_q & (merged != cmp_q);
   // Reserved and over-word sizes fall back to word
   assign wr_size   = (ap_req_i.wdata[2:0] > MAP_SIZE_WORD) ? MAP_SIZE_WORD
                                                          : ap_req_i.wdata[2:0];

   always_comb begin
      state_d = state_q;
      size_d  = size_q;
      inc_d   = inc_q;
      swen_d  = swen_q;
      tar_d   = tar_q;
      drw_d   = drw_q;
      rdata_d = rdata_q;
      cmp_d   = cmp_q;
      beats_d = beats_q;
      write_d = write_q;
      push_d  = push_q;
      err_d   = err_q;
      unique case (state_q)
         MAP_ST_IDLE: begin
            if (take) begin
               write_d = ap_req_i.write;
               push_d  = ap_req_i.push;
               err_d   = 1'b0;
               state_d = MAP_ST_RESP;
               if (ap_req_i.sel == MAP_SEL_CSW) begin
                  rdata_d = csw_rd;
                  if (ap_req_i.write) begin
                     size_d = wr_size;
                     inc_d  = ap_req_i.wdata[MAP_CSW_INC_LSB +: 2];
                     swen_d = ap_req_i.wdata[MAP_CSW_SWEN_BIT];
                  end
               end else if (ap_req_i.sel == MAP_SEL_TAR) begin
                  rdata_d = tar_q;
                  if (ap_req_i.write)
                     tar_d = ap_req_i.wdata;
               end else if (ap_req_i.sel == MAP_SEL_DRW) begin
                  beats_d = beats_init;
                  state_d = MAP_ST_XFER;
                  if (ap_req_i.write)
                     drw_d = ap_req_i.wdata;
                  else
                     cmp_d = ap_req_i.wdata;
               end else begin
                  rdata_d = 32'h0;
               end
            end
         end
         MAP_ST_XFER: begin
            if (beat_err) begin
               // (R11) stop at the failing access
               err_d   = 1'b1;
               rdata_d = drw_q;
               state_d = MAP_ST_RESP;
            end else if (beat_ok) begin
               if (!write_q)
                  drw_d = merged;
               // (R6) (R7) step address upward on success
               if (inc_q != MAP_INC_OFF)
                  tar_d = tar_q + step;
               beats_d = beats_q - 3'h1;
               if (beats_q == 3'h1) begin
                  rdata_d = write_q ? drw_q : merged;
                  state_d = MAP_ST_RESP;
               end
            end
         end
         MAP_ST_RESP: begin
            state_d = MAP_ST_IDLE;
         end
         default: begin
            state_d = MAP_ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clock_i) begin
      if (!nrst_i) begin
         state_q <= MAP_ST_IDLE;
         size_q  <= MAP_SIZE_RST;
         inc_q   <= MAP_INC_RST;
         swen_q  <= MAP_SWEN_RST;
         tar_q   <= MAP_TAR_RST;
         drw_q   <= MAP_DRW_RST;
         rdata_q <= 32'h0;
         cmp_q   <= 32'h0;
         beats_q <= 3'h0;
         write_q <= 1'b0;
         push_q  <= 1'b0;
         err_q   <= 1'b0;
      end else begin
         state_q <= state_d;
         size_q  <= size_d;
         inc_q   <= inc_d;
         swen_q  <= swen_d;
         tar_q   <= tar_d;
         drw_q   <= drw_d;
         rdata_q <= rdata_d;
         cmp_q   <= cmp_d;
         beats_q <= beats_d;
         write_q <= write_d;
         push_q  <= push_d;
         err_q   <= err_d;
      end
   end

   // (R21) sticky flags, a set beats a clear
   always_ff @(posedge clock_i) begin
      if (!nrst_i) begin
         serr_q <= 1'b0;
         scmp_q <= 1'b0;
      end else begin
         serr_q <= beat_err | (serr_q & ~sticky_clr_i);
         scmp_q <= cmp_miss | (scmp_q & ~sticky_clr_i);
      end
   end

   assign ap_resp_valid_o = (state_q == MAP_ST_RESP);
   assign ap_rdata_o      = rdata_q;
   assign ap_err_o        = err_q;
   assign sticky_err_o    = serr_q;
   assign sticky_cmp_o    = scmp_q;

   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!nrst_i);

   a_busy_not_ready: assert property (
      state_q != MAP_ST_IDLE |-> !ap_ready_o) // R23
      else $error("ready raised while a sequence runs");
   a_packed_word_one: assert property (
      take_drw && packed_on && size_q == MAP_SIZE_WORD
      |=> beats_q == 3'h1) // R2
      else $error("packed word did not give one access");
   a_packed_half_two: assert property (
      take_drw && packed_on && size_q == MAP_SIZE_HALF
      |=> beats_q == 3'h2) // R3
      else $error("packed halfword did not give two accesses");
   a_packed_byte_four: assert property (
      take_drw && packed_on && size_q == MAP_SIZE_BYTE
      |=> beats_q == 3'h4) // R4
      else $error("packed byte did not give four accesses");
   a_plain_single: assert property (
      take_drw && !packed_on |=> beats_q == 3'h1) // R22
      else $error("non-packed access split");
   a_tar_step_ok: assert property (
      beat_ok && packed_on |=> tar_q == $past(tar_q) + $past(step)) // R6
      else $error("address not advanced by access size");
   a_next_ascends: assert property (
      beat_ok && beats_q != 3'h1 && packed_on
      |=> dbg_valid && dbg_req.addr == $past(dbg_req.addr) + $past(step))
      // R7
      else $error("packed accesses not ascending");
   a_half_lane_pick: assert property (
      dbg_valid && size_q == MAP_SIZE_HALF
      |-> dbg_req.be == (tar_q[1] ? 4'hC : 4'h3)) // R8
      else $error("halfword lane wrong");
   a_byte_lane_pick: assert property (
      dbg_valid && size_q == MAP_SIZE_BYTE && tar_q[1:0] == 2'h2
      |-> dbg_req.be == 4'h4) // R9
      else $error("byte lane wrong");
   // A finished data read answers with the whole packed word
   a_read_whole_word: assert property (
      ap_resp_valid_o && $past(state_q == MAP_ST_XFER) && !err_q && !write_q
      |-> ap_rdata_o == drw_q && $past(beats_q) == 3'h1) // R10
      else $error("read answered without assembled word");
   a_error_halts: assert property (
      beat_err |=> ap_resp_valid_o && ap_err_o && tar_q == $past(tar_q))
      // R11
      else $error("error did not stop the sequence");
   a_error_sticky: assert property (beat_err |=> sticky_err_o) // R21
      else $error("sticky error not set");
   a_cmp_after_word: assert property (
      $rose(sticky_cmp_o) |-> $past(last_beat)) // R12
      else $error("compare flag set before word complete");
   a_gate_follows: assert property (
      software_debug_gate_o == (HAS_SW_GATE && (swen_q || ap_disabled_i)))
      // R19
      else $error("gate does not follow enable");
   a_enable_reset: assert property (
      disable iff (1'b0) $past(!nrst_i) |-> swen_q && software_debug_gate_o)
      // R18
      else $error("enable bit did not reset to one");
   a_refuse_slave: assert property (
      slv_valid_i && !swen_eff |-> slv_done_o && slv_rsp_o.err) // R15
      else $error("disabled slave port not refused");

   c_packed_byte_rd: cover property (
      take_drw && packed_on && size_q == MAP_SIZE_BYTE && !ap_req_i.write
      ##[4:40] ap_resp_valid_o && !ap_err_o);
   c_packed_error: cover property (beat_err && beats_q != beats_init);
   c_pushed_miss: cover property (cmp_miss);
endmodule // map_packer
`default_nettype wire

// [map_pkg.sv]
`default_nettype none
package map_pkg;
   // Register select codes on the access-port request
   localparam logic [1:0] MAP_SEL_CSW = 2'h0;
   localparam logic [1:0] MAP_SEL_TAR = 2'h1;
   localparam logic [1:0] MAP_SEL_DRW = 2'h3;
   // Control status word fields
   localparam int MAP_CSW_SIZE_LSB = 0;
   localparam int MAP_CSW_INC_LSB  = 4;
   localparam int MAP_CSW_BUSY_BIT = 7;
   localparam int MAP_CSW_SWEN_BIT = 31;
   // Access sizes
   localparam logic [2:0] MAP_SIZE_BYTE = 3'h0;
   localparam logic [2:0] MAP_SIZE_HALF = 3'h1;
   localparam logic [2:0] MAP_SIZE_WORD = 3'h2;
   // Address increment modes
   localparam logic [1:0] MAP_INC_OFF    = 2'h0;
   localparam logic [1:0] MAP_INC_SINGLE = 2'h1;
   localparam logic [1:0] MAP_INC_PACKED = 2'h2;
   // Reset values
   localparam logic [2:0]  MAP_SIZE_RST = MAP_SIZE_WORD;
   localparam logic [1:0]  MAP_INC_RST  = MAP_INC_OFF;
   localparam logic        MAP_SWEN_RST = 1'b1;
   localparam logic [31:0] MAP_TAR_RST  = 32'h0000_0000;
   localparam logic [31:0] MAP_DRW_RST  = 32'h0000_0000;

   typedef struct packed {
      logic        write;
      logic        push;
      logic [1:0]  sel;
      logic [31:0] wdata;
   } map_ap_req_t;

   typedef struct packed {
      logic        write;
      logic [31:0] addr;
      logic [2:0]  size;
      logic [3:0]  be;
      logic [31:0] wdata;
   } map_mem_req_t;

   typedef struct packed {
      logic        err;
      logic [31:0] rdata;
   } map_mem_rsp_t;

   typedef enum logic [2:0] {
      MAP_ST_IDLE = 3'b001,
      MAP_ST_XFER = 3'b010,
      MAP_ST_RESP = 3'b100
   } map_state_t;
endpackage
`default_nettype wire

// [mem_access_port_packing_tb_top.sv]
`timescale 1ns/1ns
`default_nettype none
module mem_access_port_packing_tb_top
   import map_pkg::*;
();
   logic         clock_i, nrst_i, ap_valid_i, sticky_clr_i;
   logic         ap_disabled_i, slv_valid_i, mem_done_i;
   logic         ap_ready_o, ap_resp_valid_o, ap_err_o;
   logic         sticky_err_o, sticky_cmp_o, software_debug_gate_o;
   logic         slv_done_o, mem_valid_o, e;
   logic [31:0]  ap_rdata_o, err_addr, rd, t, a;
   logic [1:0]   wt;
   map_ap_req_t  ap_req_i;
   map_mem_req_t slv_req_i, mem_req_o;
   map_mem_rsp_t slv_rsp_o, mem_rsp_i;
   int           failures, samples_checked, n0;

   map_packer dut_u (.clock_i(clock_i), .nrst_i(nrst_i),
      .ap_valid_i(ap_valid_i), .ap_req_i(ap_req_i),
      .ap_ready_o(ap_ready_o), .ap_resp_valid_o(ap_resp_valid_o),
      .ap_rdata_o(ap_rdata_o), .ap_err_o(ap_err_o),
      .sticky_clr_i(sticky_clr_i), .sticky_err_o(sticky_err_o),
      .sticky_cmp_o(sticky_cmp_o), .ap_disabled_i(ap_disabled_i),
      .software_debug_gate_o(software_debug_gate_o),
      .slv_valid_i(slv_valid_i), .slv_req_i(slv_req_i),
      .slv_done_o(slv_done_o), .slv_rsp_o(slv_rsp_o),
      .mem_valid_o(mem_valid_o), .mem_req_o(mem_req_o),
      .mem_done_i(mem_done_i), .mem_rsp_i(mem_rsp_i));

   map_mem_model mm_u (.clock_i(clock_i), .valid_i(mem_valid_o),
      .req_i(mem_req_o), .wait_i(wt), .err_addr_i(err_addr),
      .done_o(mem_done_i), .rsp_o(mem_rsp_i));

   initial begin
      clock_i = 1'b0;
      forever #4 clock_i = ~clock_i;
   end

   task automatic chk(input string n, input logic [31:0] s, x);
      samples_checked++;
      if (s !== x) begin
         failures++;
         $display("FAIL %s expected %h seen %h", n, x, s);
      end
   endtask

   task automatic results();
      $display("checks %0d failures %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   // Bounded wait of one cycle; a hang ends the run
   task automatic step(inout int k);
      @(negedge clock_i);
      k++;
      if (k > 60) begin
         failures++;
         $display("FAIL timeout expected handshake");
         results();
      end
   endtask

   task automatic ap(input logic w, p, input logic [1:0] s,
                     input logic [31:0] d);
      int k;
      k = 0;
      ap_valid_i = 1'b1;
      ap_req_i   = '{write: w, push: p, sel: s, wdata: d};
      while (ap_ready_o !== 1'b1) step(k);
      @(negedge clock_i);
      ap_valid_i = 1'b0;
      while (ap_resp_valid_o !== 1'b1) begin
         chk("ready_busy", ap_ready_o, 32'h0);
         step(k);
      end
      rd = ap_rdata_o;
      e  = ap_err_o;
      @(negedge clock_i);
   endtask

   task automatic wr(input logic [1:0] s, input logic [31:0] d);
      ap(1'b1, 1'b0, s, d);
   endtask

   task automatic rdr(input logic [1:0] s);
      ap(1'b0, 1'b0, s, 32'h0);
   endtask

   task automatic slv(input logic [31:0] ad);
      int k;
      k = 0;
      slv_valid_i = 1'b1;
      slv_req_i   = '{write: 1'b1, addr: ad, size: MAP_SIZE_WORD,
                      be: 4'hF, wdata: 32'h5A5A_5A5A};
      while (slv_done_o !== 1'b1) step(k);
      e = slv_rsp_o.err;
      @(negedge clock_i);
      slv_valid_i = 1'b0;
   endtask

   task automatic clr();
      sticky_clr_i = 1'b1;
      @(negedge clock_i);
      sticky_clr_i = 1'b0;
      chk("err_clr", sticky_err_o, 32'h0);
      chk("cmp_clr", sticky_cmp_o, 32'h0);
   endtask

   initial begin
      failures = 0;
      samples_checked = 0;
      nrst_i = 1'b0;
      ap_valid_i = 1'b0;
      ap_req_i = '0;
      sticky_clr_i = 1'b0;
      ap_disabled_i = 1'b0;
      slv_valid_i = 1'b0;
      slv_req_i = '0;
      wt = 2'h0;
      err_addr = 32'hFFFF_FFFF;
      repeat (3) @(negedge clock_i);
      nrst_i = 1'b1;
      chk("gate_rst", software_debug_gate_o, 32'h1);
      rdr(MAP_SEL_CSW);
      chk("csw_rst", rd, 32'h8000_0002);
      $display("test reset done");

      // Slow memory: two counted packed halfword reads
      wt = 2'h2;
      wr(MAP_SEL_CSW, 32'h8000_0021);
      wr(MAP_SEL_TAR, 32'h0000_0002);
      rdr(MAP_SEL_DRW);
      chk("rd_half0", rd, 32'h0302_0504);
      rdr(MAP_SEL_DRW);
      chk("rd_half1", rd, 32'h0706_0908);
      rdr(MAP_SEL_TAR);
      chk("tar_rd", rd, 32'h0000_000A);
      wr(MAP_SEL_TAR, 32'h0000_0002);
      ap(1'b0, 1'b1, MAP_SEL_DRW, 32'h0302_0504);
      chk("cmp_match", sticky_cmp_o, 32'h0);
      wr(MAP_SEL_TAR, 32'h0000_0002);
      ap(1'b0, 1'b1, MAP_SEL_DRW, 32'h0000_0000);
      chk("cmp_miss", sticky_cmp_o, 32'h1);
      clr();
      wt = 2'h0;
      $display("test packed read done");

      for (int s = 0; s < 3; s++) begin
         t  = (s == 2) ? 32'h10 : 32'h12;
         n0 = mm_u.la.size();
         wr(MAP_SEL_CSW, 32'h8000_0020 | 32'(s));
         wr(MAP_SEL_TAR, t);
         wr(MAP_SEL_DRW, 32'h4433_2211);
         chk("beats", 32'(mm_u.la.size() - n0), 32'(4 >> s));
         for (int k = 0; k < (4 >> s); k++) begin
            a = t + 32'(k << s);
            chk("addr", mm_u.la[n0+k], a & ~32'((1 << s) - 1));
            chk("be", 32'(mm_u.lb[n0+k]), (s == 0) ? 32'h1 << a[1:0] :
                (s == 1) ? (a[1] ? 32'hC : 32'h3) : 32'hF);
         end
         rdr(MAP_SEL_TAR);
         chk("tar_step", rd, t + 32'h4);
      end
      wr(MAP_SEL_CSW, 32'h8000_0002);
      wr(MAP_SEL_TAR, 32'h0000_0014);
      rdr(MAP_SEL_DRW);
      chk("lanes", rd, 32'h1716_2211);
      rdr(MAP_SEL_TAR);
      chk("tar_hold", rd, 32'h0000_0014);
      wr(MAP_SEL_CSW, 32'h8000_0010);
      wr(MAP_SEL_TAR, 32'h0000_0031);
      n0 = mm_u.la.size();
      wr(MAP_SEL_DRW, 32'h0000_0000);
      chk("plain_beats", 32'(mm_u.la.size() - n0), 32'h1);
      chk("plain_be", 32'(mm_u.lb[n0]), 32'h2);
      rdr(MAP_SEL_TAR);
      chk("plain_tar", rd, 32'h0000_0032);
      $display("test packed write done");

      // Third byte of a packed write faults
      err_addr = 32'h0000_0022;
      wr(MAP_SEL_CSW, 32'h8000_0020);
      wr(MAP_SEL_TAR, 32'h0000_0020);
      n0 = mm_u.la.size();
      wr(MAP_SEL_DRW, 32'h0000_0000);
      chk("err_resp", 32'(e), 32'h1);
      chk("err_beats", 32'(mm_u.la.size() - n0), 32'h3);
      chk("sticky_err", sticky_err_o, 32'h1);
      rdr(MAP_SEL_TAR);
      chk("err_tar", rd, 32'h0000_0022);
      err_addr = 32'hFFFF_FFFF;
      clr();
      $display("test error done");

      n0 = mm_u.la.size();
      slv(32'h8000_0008);
      chk("slv_ok", 32'(e), 32'h0);
      chk("slv_addr", mm_u.la[n0], 32'h0000_0008);
      wr(MAP_SEL_TAR, 32'h0000_0008);
      rdr(MAP_SEL_DRW);
      chk("dbg_as_slv", rd, 32'h5A5A_5A5A);
      wr(MAP_SEL_CSW, 32'h0000_0022);
      chk("gate_low", software_debug_gate_o, 32'h0);
      rdr(MAP_SEL_CSW);
      chk("csw_off", rd, 32'h0000_0022);
      n0 = mm_u.la.size();
      slv(32'h8000_0008);
      chk("slv_refused", 32'(e), 32'h1);
      chk("slv_none", 32'(mm_u.la.size() - n0), 32'h0);
      ap_disabled_i = 1'b1;
      @(negedge clock_i);
      chk("gate_dis", software_debug_gate_o, 32'h1);
      slv(32'h8000_0008);
      chk("slv_dis", 32'(e), 32'h0);
      ap_disabled_i = 1'b0;
      wr(MAP_SEL_CSW, 32'h8000_0022);
      chk("gate_back", software_debug_gate_o, 32'h1);
      $display("test slave port done");
      results();
   end
endmodule // mem_access_port_packing_tb_top
`default_nettype wire
